// file: src/spw_defs.vh
/*
 * constants for the three-channel sawtooth pwm / one-shot timer:
 * register offsets, control field positions, pin action codes, reset values.
 * assumes it is included by its bare name from the design file.
 */
`ifndef SPW_DEFS_VH
`define SPW_DEFS_VH

// ----------------------------------------------------------------------------
// channel register offsets (byte address within a channel window)
// ----------------------------------------------------------------------------
`define SPW_OFF_CTRL 6'h00
`define SPW_OFF_PERIOD 6'h04
`define SPW_OFF_CMP_A 6'h08
`define SPW_OFF_CMP_B 6'h0C
`define SPW_OFF_BUF1_A 6'h10
`define SPW_OFF_BUF2_A 6'h14
`define SPW_OFF_BUF1_B 6'h18
`define SPW_OFF_BUF2_B 6'h1C
`define SPW_OFF_DT_UP 6'h20
`define SPW_OFF_DT_DN 6'h24
`define SPW_OFF_COUNTER 6'h28
`define SPW_OFF_STATUS 6'h2C

// ----------------------------------------------------------------------------
// global register addresses and channel window decode
// ----------------------------------------------------------------------------
`define SPW_ADDR_START 8'hC0
`define SPW_ADDR_CLKDIV 8'hC4
`define SPW_CH_WIN_MSB 7
`define SPW_CH_WIN_LSB 6
`define SPW_NUM_CH 3

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define SPW_F_ONESHOT 0
`define SPW_F_DBUF 1
`define SPW_F_AUTODT 2
`define SPW_F_PINSEL 3
`define SPW_F_FORCE 4
`define SPW_F_A_START 9:8
`define SPW_F_A_MATCH 11:10
`define SPW_F_A_END 13:12
`define SPW_F_A_STOP 15:14
`define SPW_F_B_START 17:16
`define SPW_F_B_MATCH 19:18
`define SPW_F_B_END 21:20
`define SPW_F_B_STOP 23:22

// ----------------------------------------------------------------------------
// pin action codes
// ----------------------------------------------------------------------------
`define SPW_ACT_RETAIN 2'h0
`define SPW_ACT_LOW 2'h1
`define SPW_ACT_HIGH 2'h2
`define SPW_ACT_TOGGLE 2'h3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SPW_RST_WORD 32'h0000_0000
`define SPW_RST_PERIOD 32'hFFFF_FFFF
`define SPW_RST_DIV 8'h00

`endif

// file: src/spw_timer.v
/*
 * three synchronised sawtooth timer channels with paired pwm pins,
 * one-shot pulse mode with double buffering and automatic dead time,
 * reached over an avalon-mm slave with waitrequest.
 * assumes one clock, an asynchronous active-low reset and a bus master
 * that holds its request until waitrequest is seen low.
 */
// Chosen here: the address map and the Avalon-MM slave port.
//
// Summary of operation
// R1: pwm pins change at match and overflow
// R2: start, match, end pin actions configurable
// R3: any duty 0% to 100% via compare
// R4: software keeps compares between one and period
// R5: compare zero or period still matches
// R6: compare above period never matches
// R7: one write starts selected channels together
// R8: software sets all start bits at once
// R9: start level driven on pin selection
// R10: counter counts up from zero to period
// R11: count clock selectable as clock divided one
// R12: one-shot: start/stop levels, toggle, retain end
// R13: a match copies temporary a into a
// R14: overflow copies both a buffers together
// R15: forced transfer performs overflow copies
// R16: compare b has its own double buffer
// R17: auto dead time derives b from a
// R18: two dead time values, one per edge
// R19: overflow raises interrupt request pulse
// R20: two compares give asymmetric halves
// R21: after start b turns off, a on
// R22: software orders buffers inside period without dead time
// R23: up value first half, down value second
// R24: counter and compare registers 32 bits
// R25: stopped: hold stop level, suspend transfers (forced transfers and control-write start levels still act)
`include "spw_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// one timer channel
// ----------------------------------------------------------------------------
module spw_channel #(
    parameter W = 32 // R24
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // timing
    input wire tick,
    input wire run,
    // register access
    input wire wr_en,
    input wire [5:0] offset,
    input wire [31:0] wdata,
    input wire [3:0] be,
    output reg [31:0] rdata,
    // pins and events
    output reg positive_phase_pin,
    output reg negative_phase_pin,
    output reg pin_function_select,
    output reg overflow_irq
);
    reg [31:0] ctrl; // mode, buffer and pin action setup
    reg [W-1:0] period_value; // top count of the carrier
    reg [W-1:0] compare_reg_a; // positive phase compare
    reg [W-1:0] compare_reg_b; // negative phase compare
    reg [W-1:0] first_buffer_a; // overflow source for a
    reg [W-1:0] second_buffer_a; // overflow source for temp a
    reg [W-1:0] first_buffer_b; // overflow source for b
    reg [W-1:0] second_buffer_b; // overflow source for temp b
    reg [W-1:0] temp_a; // second half value of a
    reg [W-1:0] temp_b; // second half value of b
    reg [W-1:0] deadtime_up_value; // first half dead time
    reg [W-1:0] deadtime_down_value; // second half dead time
    reg [W-1:0] cycle_counter; // the sawtooth
    reg run_q; // run seen last cycle
    reg [31:0] merged; // write data merged under byte enables
    reg [31:0] old_word; // current value of addressed word
    wire oneshot; // one-shot pulse mode
    wire dbuf; // double buffer transfers
    wire autodt; // automatic dead time
    wire counting; // counter advancing this cycle
    wire ovf; // end of cycle
    wire match_a; // compare a hit
    wire match_b; // compare b hit
    wire start_edge; // counting begins
    wire stop_edge; // counting ends
    wire ctrl_wr; // control register written
    wire force_xfer; // forced buffer transfer
    wire [W-1:0] a_ovf_val; // value a takes at overflow or force

    assign oneshot = ctrl[`SPW_F_ONESHOT];
    assign dbuf = ctrl[`SPW_F_DBUF];
    assign autodt = ctrl[`SPW_F_AUTODT];
    assign counting = run & run_q & tick;
    assign ovf = counting & (cycle_counter == period_value); // R1
    // exact equality: above period never hits, zero and period do
    assign match_a = counting & (cycle_counter == compare_reg_a); // R5 R6
    assign match_b = counting & (cycle_counter == compare_reg_b); // R5 R6
    assign start_edge = run & ~run_q;
    assign stop_edge = ~run & run_q;
    assign ctrl_wr = wr_en & (offset == `SPW_OFF_CTRL);
    assign force_xfer = ctrl_wr & be[0] & wdata[`SPW_F_FORCE]; // R15
    assign a_ovf_val = first_buffer_a;

    // pin action: retain, low, high or toggle
    function act;
        input cur;
        input [1:0] code;
        begin
            case (code)
                `SPW_ACT_LOW: act = 1'b0;
                `SPW_ACT_HIGH: act = 1'b1;
                `SPW_ACT_TOGGLE: act = ~cur;
                default: act = cur;
            endcase
        end
    endfunction

    // read mux and byte-enable merge
    always @* begin
        old_word = `SPW_RST_WORD;
        if (offset == `SPW_OFF_CTRL) begin
            old_word = ctrl;
        end else if (offset == `SPW_OFF_PERIOD) begin
            old_word = period_value;
        end else if (offset == `SPW_OFF_CMP_A) begin
            old_word = compare_reg_a;
        end else if (offset == `SPW_OFF_CMP_B) begin
            old_word = compare_reg_b;
        end else if (offset == `SPW_OFF_BUF1_A) begin
            old_word = first_buffer_a;
        end else if (offset == `SPW_OFF_BUF2_A) begin
            old_word = second_buffer_a;
        end else if (offset == `SPW_OFF_BUF1_B) begin
            old_word = first_buffer_b;
        end else if (offset == `SPW_OFF_BUF2_B) begin
            old_word = second_buffer_b;
        end else if (offset == `SPW_OFF_DT_UP) begin
            old_word = deadtime_up_value;
        end else if (offset == `SPW_OFF_DT_DN) begin
            old_word = deadtime_down_value;
        end else if (offset == `SPW_OFF_COUNTER) begin
            old_word = cycle_counter;
        end else if (offset == `SPW_OFF_STATUS) begin
            old_word = {30'h0000_0000, negative_phase_pin, run_q};
        end
        rdata = old_word;
        merged = {be[3] ? wdata[31:24] : old_word[31:24],
                  be[2] ? wdata[23:16] : old_word[23:16],
                  be[1] ? wdata[15:8] : old_word[15:8],
                  be[0] ? wdata[7:0] : old_word[7:0]};
    end

    // counter and run tracking
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_counter <= `SPW_RST_WORD;
            run_q <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            run_q <= run;
            overflow_irq <= ovf; // R19
            if (wr_en && offset == `SPW_OFF_COUNTER) begin
                cycle_counter <= merged;
            end else if (start_edge) begin
                // every start counts from zero, so phases line up with compares
                cycle_counter <= `SPW_RST_WORD; // R10
            end else if (ovf) begin
                cycle_counter <= `SPW_RST_WORD; // R10
            end else if (counting) begin
                cycle_counter <= cycle_counter + 1'b1; // R10
            end
        end
    end

    // pin levels: start, match, end and stop actions
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            positive_phase_pin <= 1'b0;
            negative_phase_pin <= 1'b0;
            pin_function_select <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                pin_function_select <= merged[`SPW_F_PINSEL];
            end
            if (start_edge) begin
                // R21 start levels chosen so b is off before a turns on
                positive_phase_pin <= act(positive_phase_pin, ctrl[`SPW_F_A_START]); // R2 R12
                negative_phase_pin <= act(negative_phase_pin, ctrl[`SPW_F_B_START]); // R2 R12
            end else if (stop_edge) begin
                positive_phase_pin <= act(positive_phase_pin, ctrl[`SPW_F_A_STOP]); // R12 R25
                negative_phase_pin <= act(negative_phase_pin, ctrl[`SPW_F_B_STOP]); // R12 R25
            end else if (counting) begin
                // match applied after end, so match wins on a shared count
                if (oneshot) begin
                    positive_phase_pin <= match_a ? ~positive_phase_pin
                                                  : positive_phase_pin; // R12 R20 R21
                    negative_phase_pin <= match_b ? ~negative_phase_pin
                                                  : negative_phase_pin; // R12 R20 R21
                end else begin
                    positive_phase_pin <= act(act(positive_phase_pin,
                        ovf ? ctrl[`SPW_F_A_END] : `SPW_ACT_RETAIN),
                        match_a ? ctrl[`SPW_F_A_MATCH] : `SPW_ACT_RETAIN); // R1 R2 R3
                    negative_phase_pin <= act(act(negative_phase_pin,
                        ovf ? ctrl[`SPW_F_B_END] : `SPW_ACT_RETAIN),
                        match_b ? ctrl[`SPW_F_B_MATCH] : `SPW_ACT_RETAIN); // R1 R2 R3
                end
            end else if (ctrl_wr && !run_q) begin
                // initial level appears as soon as the pin is set up
                positive_phase_pin <= act(positive_phase_pin, merged[`SPW_F_A_START]); // R9
                negative_phase_pin <= act(negative_phase_pin, merged[`SPW_F_B_START]); // R9
            end
        end
    end

    // configuration, compare and buffer registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `SPW_RST_WORD;
            period_value <= `SPW_RST_PERIOD;
            compare_reg_a <= `SPW_RST_WORD;
            compare_reg_b <= `SPW_RST_WORD;
            first_buffer_a <= `SPW_RST_WORD;
            second_buffer_a <= `SPW_RST_WORD;
            first_buffer_b <= `SPW_RST_WORD;
            second_buffer_b <= `SPW_RST_WORD;
            temp_a <= `SPW_RST_WORD;
            temp_b <= `SPW_RST_WORD;
            deadtime_up_value <= `SPW_RST_WORD;
            deadtime_down_value <= `SPW_RST_WORD;
        end else begin
            // hardware transfers only while counting in one-shot double buffer
            if (force_xfer || (oneshot && dbuf && ovf)) begin
                temp_a <= second_buffer_a; // R14 R15
                compare_reg_a <= a_ovf_val; // R14 R15
                if (autodt) begin
                    compare_reg_b <= a_ovf_val - deadtime_up_value; // R17 R18 R23
                end else begin
                    temp_b <= second_buffer_b; // R16
                    compare_reg_b <= first_buffer_b; // R16
                end
            end else if (oneshot && dbuf) begin
                if (match_a) begin
                    compare_reg_a <= temp_a; // R13
                    if (autodt) begin
                        compare_reg_b <= temp_a + deadtime_down_value; // R17 R18 R23
                    end
                end
                if (match_b && !autodt) begin
                    compare_reg_b <= temp_b; // R16
                end
            end
            // software writes, unmapped offsets fall through
            if (wr_en) begin
                if (offset == `SPW_OFF_CTRL) begin
                    ctrl <= merged & ~(32'h0000_0001 << `SPW_F_FORCE);
                end else if (offset == `SPW_OFF_PERIOD) begin
                    period_value <= merged;
                end else if (offset == `SPW_OFF_CMP_A) begin
                    compare_reg_a <= merged;
                end else if (offset == `SPW_OFF_CMP_B) begin
                    compare_reg_b <= merged;
                end else if (offset == `SPW_OFF_BUF1_A) begin
                    first_buffer_a <= merged;
                end else if (offset == `SPW_OFF_BUF2_A) begin
                    second_buffer_a <= merged;
                end else if (offset == `SPW_OFF_BUF1_B) begin
                    first_buffer_b <= merged;
                end else if (offset == `SPW_OFF_BUF2_B) begin
                    second_buffer_b <= merged;
                end else if (offset == `SPW_OFF_DT_UP) begin
                    deadtime_up_value <= merged;
                end else if (offset == `SPW_OFF_DT_DN) begin
                    deadtime_down_value <= merged;
                end
            end
        end
    end
endmodule // spw_channel

// ----------------------------------------------------------------------------
// top: bus slave, count clock divider, shared start register
// ----------------------------------------------------------------------------
module spw_timer (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    // pins
    output wire [2:0] positive_phase_pin,
    output wire [2:0] negative_phase_pin,
    output wire [2:0] pin_function_select,
    // overflow interrupt request pulses
    output wire [2:0] overflow_irq
);
    reg [1:0] rst_sync; // reset release synchroniser
    wire rst_n_int; // synchronised reset
    reg [2:0] soft_start_register; // one run bit per channel
    reg [7:0] clk_div; // count clock divide minus one
    reg [7:0] div_cnt; // divider counter
    reg tick; // count clock enable
    wire req; // request held by master
    wire done; // request completes this edge
    wire [1:0] ch_idx; // addressed channel
    wire [31:0] ch_rdata [0:2]; // per-channel read words

    assign rst_n_int = rst_sync[1];
    assign req = read | write;
    assign done = req & ~waitrequest;
    assign ch_idx = address[`SPW_CH_WIN_MSB:`SPW_CH_WIN_LSB];

    // reset synchroniser: async assert, two-flop release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // count clock enable: divide by clk_div plus one, zero gives every cycle
    always @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            div_cnt <= `SPW_RST_DIV;
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == `SPW_RST_DIV); // R11
            div_cnt <= (div_cnt == `SPW_RST_DIV) ? clk_div : div_cnt - 1'b1; // R11
        end
    end

    // bus handshake: one wait cycle, data and write at the low edge
    always @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            waitrequest <= 1'b1;
            readdata <= `SPW_RST_WORD;
        end else begin
            waitrequest <= ~(req & waitrequest);
            // only a read moves the read data, writes leave it standing
            if (read && waitrequest) begin
                if (address == `SPW_ADDR_START) begin
                    readdata <= {29'h0000_0000, soft_start_register};
                end else if (address == `SPW_ADDR_CLKDIV) begin
                    readdata <= {24'h00_0000, clk_div};
                end else if (ch_idx < `SPW_NUM_CH) begin
                    readdata <= ch_rdata[ch_idx];
                end else begin
                    readdata <= `SPW_RST_WORD;
                end
            end
        end
    end

    // shared start register, all bits land on one edge
    always @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            soft_start_register <= 3'h0;
            clk_div <= `SPW_RST_DIV;
        end else if (done && write && byteenable[0]) begin
            if (address == `SPW_ADDR_START) begin
                soft_start_register <= writedata[2:0]; // R7
            end else if (address == `SPW_ADDR_CLKDIV) begin
                clk_div <= writedata[7:0]; // R11
            end
        end
    end

    // channel instances
    genvar g;
    generate
        for (g = 0; g < `SPW_NUM_CH; g = g + 1) begin : gen_ch
            spw_channel #(
                .W(32)
            ) u_ch (
                .clk(clk),
                .rst_n(rst_n_int),
                .tick(tick),
                .run(soft_start_register[g]), // R7
                .wr_en(done & write & (ch_idx == g)),
                .offset(address[5:0]),
                .wdata(writedata),
                .be(byteenable),
                .rdata(ch_rdata[g]),
                .positive_phase_pin(positive_phase_pin[g]),
                .negative_phase_pin(negative_phase_pin[g]),
                .pin_function_select(pin_function_select[g]),
                .overflow_irq(overflow_irq[g])
            );
        end
    endgenerate
endmodule // spw_timer

`default_nettype wire

// file: verif/spw_timer_props.sv
/* checker for the sawtooth timer top: bus handshake, read data, irq pulses.
   assumes one clock domain and the reset polarity of the top. */
`timescale 1ns/1ps
`default_nettype none
module spw_timer_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // pins and events
    input wire logic [2:0] positive_phase_pin,
    input wire logic [2:0] negative_phase_pin,
    input wire logic [2:0] pin_function_select,
    input wire logic [2:0] overflow_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // handshake steps
    // ---------------------------------------------------------------
    sequence bus_taken;
        (read || write) && waitrequest;
    endsequence
    sequence bus_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    sequence unmapped_read;
        read && waitrequest && ((address[7:6] != 2'h3 && address[5:0] > 6'h2F) || address > 8'hC7);
    endsequence
    chk_wait_one_cycle: assert property (bus_taken |=> bus_answer)
        else $error("bus answer not one cycle after request");
    chk_wait_idle_high: assert property (!(read || write) && waitrequest |=> waitrequest)
        else $error("answer without request");
    chk_wait_fall_cause: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("waitrequest fell with no request");
    chk_rdata_hold: assert property ($changed(readdata) |-> $past(read))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (unmapped_read |=> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_pin_sel_cause: assert property ($changed(pin_function_select) |-> $past(write))
        else $error("pin selection moved without a write");
    chk_irq_one_pulse: assert property ((overflow_irq & $past(overflow_irq)) == 3'h0)
        else $error("overflow request longer than one cycle");
    chk_irq_period_gap: assert property (overflow_irq[0] |=> !overflow_irq[0] [*3])
        else $error("overflow requests too close");
endmodule // spw_timer_props
bind spw_timer spw_timer_props spw_timer_props_i (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .positive_phase_pin(positive_phase_pin), .negative_phase_pin(negative_phase_pin),
    .pin_function_select(pin_function_select), .overflow_irq(overflow_irq));
`default_nettype wire

// file: verif/spw_switch_model.sv
/* model of the complementary switch pairs on the pwm pins: counts on-time
   of each switch and cycles with both switches on, inside a window.
   assumes the bench raises win for a whole number of cycles. */
`timescale 1ns/1ps
`default_nettype none
module spw_switch_model (
    // clock and window
    input wire logic clk,
    input wire logic win,
    // pins
    input wire logic [2:0] positive_phase_pin,
    input wire logic [2:0] negative_phase_pin,
    // on-time counts
    output var int hi_a [3],
    output var int hi_b [3],
    output var int both [3]
);
    logic win_q = 1'b0; // window seen last cycle
    // counts restart on the first cycle of a window
    always @(posedge clk) begin
        win_q <= win;
        for (int i = 0; i < 3; i++) begin
            if (win) begin
                hi_a[i] <= (win_q ? hi_a[i] : 0) + int'(positive_phase_pin[i]);
                hi_b[i] <= (win_q ? hi_b[i] : 0) + int'(negative_phase_pin[i]);
                both[i] <= (win_q ? both[i] : 0) + int'(positive_phase_pin[i] & negative_phase_pin[i]);
            end
        end
    end
endmodule // spw_switch_model
`default_nettype wire

// file: verif/spw_timer_tb.sv
/* self-checking bench for the sawtooth timer: register access, pwm duty,
   one-shot double buffering with dead time, stop levels.
   assumes the switch model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module spw_timer_tb;
    logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, win = 1'b0;
    logic [7:0] address = 8'h00;
    logic [3:0] byteenable = 4'hF; // full words only
    logic [31:0] writedata = 32'h0000_0000, readdata, q;
    logic waitrequest;
    logic [2:0] pos, neg, sel, irq;
    int hi_a [3], hi_b [3], both [3], cmps [5];
    int err_total = 0, checked = 0, skew = 0, p, b1, b2, dt;
    spw_timer spw_timer_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .positive_phase_pin(pos),
        .negative_phase_pin(neg), .pin_function_select(sel), .overflow_irq(irq));
    spw_switch_model spw_switch_model_i (.clk(clk), .win(win), .positive_phase_pin(pos),
        .negative_phase_pin(neg), .hi_a(hi_a), .hi_b(hi_b), .both(both));
    initial forever #2 clk = ~clk;
    // channels started together overflow together
    always @(posedge clk) if (rst_n && irq !== 3'h0 && irq !== 3'h7) skew <= skew + 1;
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task results;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(string name, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one avalon cycle, held until waitrequest is seen low
    task bus(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        address <= a; writedata <= d; write <= wr; read <= !wr; n = 0;
        do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
        q = readdata; read <= 1'b0; write <= 1'b0;
        if (n >= 50) begin err_total++; results(); end
        @(posedge clk);
    endtask
    task wait_irq;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (irq[0] !== 1'b1 && n < 3000);
        if (n >= 3000) begin err_total++; results(); end
    endtask
    task measure(int n);
        win <= 1'b1; repeat (n) @(posedge clk); win <= 1'b0; @(posedge clk);
    endtask
    // cycles high of a pin set at compare and cleared at cycle end
    function automatic int pwm_hi(int per, int cv);
        return cv == per ? per + 1 : (cv > per ? 0 : per - cv);
    endfunction
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hafcc));
        repeat (5) @(posedge clk); rst_n <= 1'b1; repeat (3) @(posedge clk);
        bus(0, 8'h44, 0); chk("period reset", 32'hFFFF_FFFF, q);
        bus(0, 8'h80, 0); chk("ctrl reset", 32'h0000_0000, q);
        bus(0, 8'hF0, 0); chk("unmapped read", 32'h0000_0000, q);
        bus(0, 8'hC4, 0); chk("clock divide", 32'h0000_0000, q);
        bus(1, 8'h88, 32'hA5A5_5A5A); bus(0, 8'h88, 0); chk("compare width", 32'hA5A5_5A5A, q);
        p = 16 + $urandom_range(24);
        for (int ch = 0; ch < 3; ch++) begin
            bus(1, {ch[1:0], 6'h04}, p);
            bus(1, {ch[1:0], 6'h00}, 32'h0026_1908);
        end
        chk("start level a", 3'h0, pos);
        chk("start level b", 3'h7, neg);
        chk("pin select", 3'h7, sel);
        cmps = '{0, p, p + 3, 1, 2 + $urandom_range(p - 3)};
        foreach (cmps[k]) begin
            for (int ch = 0; ch < 3; ch++) begin
                bus(1, {ch[1:0], 6'h08}, cmps[k]);
                bus(1, {ch[1:0], 6'h0C}, cmps[k]);
            end
            bus(1, 8'hC0, 32'h0000_0007);
            wait_irq;
            measure(p + 1);
            for (int ch = 0; ch < 3; ch++) begin
                chk("pwm a high", pwm_hi(p, cmps[k]), hi_a[ch]);
                chk("pwm b high", p + 1 - pwm_hi(p, cmps[k]), hi_b[ch]);
            end
            bus(1, 8'hC0, 32'h0000_0000);
        end
        chk("start skew", 0, skew);
        dt = 2;
        b1 = 3 + $urandom_range(3);
        b2 = b1 + 2 + $urandom_range(p - b1 - 6);
        bus(1, 8'h10, b1); bus(1, 8'h14, b2);
        bus(1, 8'h20, dt); bus(1, 8'h24, dt);
        bus(1, 8'h00, 32'h0041_820F);
        bus(1, 8'h00, 32'h0041_821F);
        bus(0, 8'h08, 0); chk("forced compare a", b1, q);
        bus(0, 8'h0C, 0); chk("derived compare b", b1 - dt, q);
        bus(1, 8'hC0, 32'h0000_0001);
        wait_irq;
        measure(p + 1);
        chk("one-shot a high", p + 1 - (b2 - b1), hi_a[0]);
        chk("one-shot b high", b2 + dt - (b1 - dt), hi_b[0]);
        chk("switch overlap", 2 * dt, both[0]);
        bus(1, 8'hC0, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("stop level a", 1'b1, pos[0]);
        chk("stop level b", 1'b0, neg[0]);
        results();
    end
endmodule // spw_timer_tb
`default_nettype wire
